// ---- adcsf_cfg.svh ----
`ifndef ADCSF_CFG_SVH
`define ADCSF_CFG_SVH

// System clock period in ns
`define ADCSF_CLK_PERIOD_NS     10
// Internal conversion time in ns (round up to whole cycles)
`define ADCSF_T_CONV_NS         1000
`define ADCSF_CONV_CYC          ((`ADCSF_T_CONV_NS + `ADCSF_CLK_PERIOD_NS - 1) / `ADCSF_CLK_PERIOD_NS)
// Exit delay after a power-on style reset in ns
`define ADCSF_T_POR_EXIT_NS     50000
`define ADCSF_POR_EXIT_CYC      ((`ADCSF_T_POR_EXIT_NS + `ADCSF_CLK_PERIOD_NS - 1) / `ADCSF_CLK_PERIOD_NS)
// Exit delay after an application reset in ns
`define ADCSF_T_APP_EXIT_NS     2000
`define ADCSF_APP_EXIT_CYC      ((`ADCSF_T_APP_EXIT_NS + `ADCSF_CLK_PERIOD_NS - 1) / `ADCSF_CLK_PERIOD_NS)
// Frame word width and clock counter layout
`define ADCSF_WORD_BITS         32
`define ADCSF_CNT_BITS          6
`define ADCSF_CNT_OPTIMAL       6'h20
`define ADCSF_CNT_SAT           6'h21
`define ADCSF_CNT_FIRST         6'h01
// Pending command after a frame opens, a no-operation
`define ADCSF_NOP_WORD          32'h0000_0000
// Delay timer width
`define ADCSF_TMR_BITS          16
// Reset value of the stored reset type, power-on style
`define ADCSF_RTYPE_RST         1'b0

`endif

// ---- adcsf_pkg.sv ----
package adcsf_pkg;

    // Operating states, Gray coded along reset, exit, acquire, frame, convert
    typedef enum logic [2:0] {
        ADCSF_ST_RESET = 3'h0,
        ADCSF_ST_EXIT  = 3'h1,
        ADCSF_ST_ACQ   = 3'h3,
        ADCSF_ST_FRAME = 3'h2,
        ADCSF_ST_CONV  = 3'h6
    } adcsf_state_t;

endpackage : adcsf_pkg

// ---- adcsf_sync.sv ----
`timescale 1ns/1ps

// Three-stage synchroniser; the output moves only once stages two and three agree
module adcsf_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);

    logic s1_q;   // First stage, read only by the second stage
    logic s2_q;   // Second stage
    logic s3_q;   // Third stage
    logic q_q;    // Filtered level
    logic q_d;

    // Accept a new level only when two settled stages agree
    always_comb begin
        q_d = (s2_q == s3_q) ? s3_q : q_q;
    end

    // Register chain
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_q  <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q  <= q_d;
        end
    end

    assign q_o = q_q;

endmodule : adcsf_sync

// ---- adcsf_top.sv ----
`timescale 1ns/1ps
`include "adcsf_cfg.svh"

module adcsf_top #(
    parameter int unsigned CONV_CYC     = `ADCSF_CONV_CYC,     // Conversion length in clocks
    parameter int unsigned POR_EXIT_CYC = `ADCSF_POR_EXIT_CYC, // Power-on exit delay in clocks
    parameter int unsigned APP_EXIT_CYC = `ADCSF_APP_EXIT_CYC  // Application exit delay in clocks
) (
    input  wire logic        mclk_i,                      // System clock, 100 MHz
    input  wire logic        rst_i,                       // Asynchronous reset, active high
    input  wire logic        sclk_i,                      // Serial clock from the host
    input  wire logic        reset_pin_n_i,               // Device reset pin, active low
    input  wire logic        convert_start_select_i,      // Select and convert start line
    input  wire logic        serial_in_i,                 // Serial data in
    input  wire logic        reset_type_select_i,         // 1 selects application reset
    input  wire logic [31:0] conv_data_i,                 // Result word from the converter core
    output logic             primary_serial_out_o,        // Serial data out
    output logic             primary_serial_out_oe_o,     // Output enable of the serial out
    output logic             ready_valid_indicator_o,     // Ready indicator
    output logic [31:0]      cmd_word_o,                  // Command handed to the command processor
    output logic             cmd_valid_o,                 // One-cycle pulse with a valid command
    output logic             app_reset_o,                 // Configuration defaults being forced
    output logic             por_reset_o,                 // Internal circuitry held in reset
    output logic             conv_busy_o                  // Conversion in progress
);

    localparam int unsigned WB = `ADCSF_WORD_BITS;
    localparam int unsigned CB = `ADCSF_CNT_BITS;
    localparam int unsigned TB = `ADCSF_TMR_BITS;

    // Link-side reset: either reset source stops the link at once
    logic lnk_rst;
    // Frame-side reset: also clears the frame-open flags while select is high
    logic frame_rst;

    assign lnk_rst   = rst_i | ~reset_pin_n_i;
    assign frame_rst = lnk_rst | convert_start_select_i;

    // Result word, written on the system clock at conversion end
    logic [WB-1:0] out_word_q;
    logic [WB-1:0] out_word_d;

    // Link-domain state
    logic          started_q;   // A capture edge has happened in this frame
    logic          started_d;
    logic          launched_q;  // A launch edge has happened in this frame
    logic          launched_d;
    logic [WB-1:0] shr_q;       // Unified shift register
    logic [WB-1:0] shr_d;
    logic [WB-1:0] shr_base;    // Word shifted at this capture
    logic [CB-1:0] cnt_q;       // Capture edge counter, saturating
    logic [CB-1:0] cnt_d;
    logic          tog_q;       // Flips once per frame with edges
    logic          tog_d;
    logic          launch_q;    // Bit driven since the last launch edge
    logic          launch_d;

    // Capture edge next values; the first capture loads the result word
    always_comb begin
        shr_base = started_q ? shr_q : out_word_q;
        shr_d    = {shr_base[WB-2:0], serial_in_i};
        if (!started_q) begin
            cnt_d = `ADCSF_CNT_FIRST;
        end else if (cnt_q == `ADCSF_CNT_SAT) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + `ADCSF_CNT_FIRST;
        end
        tog_d     = started_q ? tog_q : ~tog_q;
        started_d = 1'b1;
    end

    // Frame-open flag, cleared whenever select is high
    always_ff @(posedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            started_q <= 1'b0;
        end else begin
            started_q <= started_d;
        end
    end

    // Counter and shift register survive select rising so the system side can read them
    always_ff @(posedge sclk_i or posedge lnk_rst) begin
        if (lnk_rst) begin
            shr_q <= `ADCSF_NOP_WORD;
            cnt_q <= '0;
            tog_q <= 1'b0;
        end else begin
            shr_q <= shr_d;
            cnt_q <= cnt_d;
            tog_q <= tog_d;
        end
    end

    // Launch edge next values
    always_comb begin
        launch_d   = shr_q[WB-1];
        launched_d = 1'b1;
    end

    // Launch edge registers on the falling serial clock
    always_ff @(negedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            launch_q   <= 1'b0;
            launched_q <= 1'b0;
        end else begin
            launch_q   <= launch_d;
            launched_q <= launched_d;
        end
    end

    // Before the first launch the result MSB is shown straight away
    assign primary_serial_out_o    = launched_q ? launch_q : out_word_q[WB-1];
    // Drive only inside a frame and outside reset
    assign primary_serial_out_oe_o = ~frame_rst;

    // Synchronised copies of select, reset pin and the frame toggle
    logic cs_s;
    logic pin_s;
    logic tog_s;

    // Select idles high, so its copy resets high and no false edge follows reset
    adcsf_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .clk_i (mclk_i),
        .rst_i (rst_i),
        .d_i   (convert_start_select_i),
        .q_o   (cs_s)
    );

    adcsf_sync #(.RST_VAL(1'b0)) u_sync_pin (
        .clk_i (mclk_i),
        .rst_i (rst_i),
        .d_i   (reset_pin_n_i),
        .q_o   (pin_s)
    );

    adcsf_sync #(.RST_VAL(1'b0)) u_sync_tog (
        .clk_i (mclk_i),
        .rst_i (rst_i),
        .d_i   (tog_q),
        .q_o   (tog_s)
    );

    // System-domain state
    adcsf_pkg::adcsf_state_t state_q;
    adcsf_pkg::adcsf_state_t state_d;
    logic          cs_prev_q;    // Select level one cycle ago
    logic          pin_prev_q;   // Reset pin level one cycle ago
    logic          tog_seen_q;   // Toggle value at the previous frame close
    logic          tog_seen_d;
    logic [TB-1:0] tmr_q;        // Exit and conversion timer
    logic [TB-1:0] tmr_d;
    logic          rtype_q;      // Reset type caught at reset entry
    logic          rtype_d;
    logic [WB-1:0] cmd_q;        // Pending command word
    logic [WB-1:0] cmd_d;
    logic          cmd_vld_q;
    logic          cmd_vld_d;
    logic          ready_q;
    logic          ready_d;
    logic          cs_rise;
    logic          cs_fall;
    logic          pin_fall;
    logic          edges_seen;   // At least one capture edge in the closing frame

    assign cs_rise    = cs_s & ~cs_prev_q;
    assign cs_fall    = ~cs_s & cs_prev_q;
    assign pin_fall   = ~pin_s & pin_prev_q;
    assign edges_seen = (tog_s != tog_seen_q);

    // Next state, timer, command hand-over and ready
    always_comb begin
        state_d    = state_q;
        tmr_d      = tmr_q;
        rtype_d    = rtype_q;
        cmd_d      = cmd_q;
        cmd_vld_d  = 1'b0;
        tog_seen_d = tog_seen_q;
        out_word_d = out_word_q;
        if (pin_fall) begin
            rtype_d = reset_type_select_i;
        end
        case (state_q)
            adcsf_pkg::ADCSF_ST_RESET: begin
                // Leave only once the pin is high; delay depends on reset type
                if (pin_s) begin
                    state_d = adcsf_pkg::ADCSF_ST_EXIT;
                    tmr_d   = rtype_q ? TB'(APP_EXIT_CYC) : TB'(POR_EXIT_CYC);
                end
            end
            adcsf_pkg::ADCSF_ST_EXIT: begin
                if (tmr_q <= TB'(1)) begin
                    state_d = adcsf_pkg::ADCSF_ST_ACQ;
                end else begin
                    tmr_d = tmr_q - TB'(1);
                end
            end
            adcsf_pkg::ADCSF_ST_ACQ: begin
                if (cs_fall) begin
                    state_d = adcsf_pkg::ADCSF_ST_FRAME;
                    cmd_d   = `ADCSF_NOP_WORD;
                end else if (cs_rise) begin
                    state_d = adcsf_pkg::ADCSF_ST_CONV;
                    tmr_d   = TB'(CONV_CYC);
                end
            end
            adcsf_pkg::ADCSF_ST_FRAME: begin
                if (cs_rise) begin
                    state_d    = adcsf_pkg::ADCSF_ST_CONV;
                    tmr_d      = TB'(CONV_CYC);
                    tog_seen_d = tog_s;
                    // Shift register is quiet here: the serial clock has stopped
                    if (edges_seen && (cnt_q >= `ADCSF_CNT_OPTIMAL)) begin
                        cmd_d     = shr_q;
                        cmd_vld_d = 1'b1;
                    end
                    // A short frame leaves the pending word a no-operation
                end
            end
            adcsf_pkg::ADCSF_ST_CONV: begin
                // Select is not looked at here
                if (tmr_q <= TB'(1)) begin
                    state_d    = adcsf_pkg::ADCSF_ST_ACQ;
                    out_word_d = conv_data_i;
                end else begin
                    tmr_d = tmr_q - TB'(1);
                end
            end
            default: begin
                state_d = adcsf_pkg::ADCSF_ST_RESET;
            end
        endcase
        // A low reset pin wins over every state
        if (!pin_s) begin
            state_d    = adcsf_pkg::ADCSF_ST_RESET;
            tmr_d      = '0;
            cmd_d      = `ADCSF_NOP_WORD;
            // The pin also clears the link toggle, so keep the seen copy in step
            tog_seen_d = 1'b0;
        end
        ready_d = (state_d == adcsf_pkg::ADCSF_ST_ACQ);
    end

    // System-domain registers; power-up also enters reset with power-on type
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q    <= adcsf_pkg::ADCSF_ST_RESET;
            tmr_q      <= '0;
            rtype_q    <= `ADCSF_RTYPE_RST;
            cmd_q      <= `ADCSF_NOP_WORD;
            cmd_vld_q  <= 1'b0;
            tog_seen_q <= 1'b0;
            ready_q    <= 1'b0;
            cs_prev_q  <= 1'b1;
            pin_prev_q <= 1'b0;
            out_word_q <= '0;
        end else begin
            state_q    <= state_d;
            tmr_q      <= tmr_d;
            rtype_q    <= rtype_d;
            cmd_q      <= cmd_d;
            cmd_vld_q  <= cmd_vld_d;
            tog_seen_q <= tog_seen_d;
            ready_q    <= ready_d;
            cs_prev_q  <= cs_s;
            pin_prev_q <= pin_s;
            out_word_q <= out_word_d;
        end
    end

    assign ready_valid_indicator_o = ready_q;
    assign cmd_word_o              = cmd_q;
    assign cmd_valid_o             = cmd_vld_q;
    assign conv_busy_o             = (state_q == adcsf_pkg::ADCSF_ST_CONV);
    // Reset kind shown while in reset or its exit delay
    assign app_reset_o = rtype_q & ((state_q == adcsf_pkg::ADCSF_ST_RESET) |
                                    (state_q == adcsf_pkg::ADCSF_ST_EXIT));
    assign por_reset_o = ~rtype_q & ((state_q == adcsf_pkg::ADCSF_ST_RESET) |
                                     (state_q == adcsf_pkg::ADCSF_ST_EXIT));

    // Checks on the system clock
    localparam int A_CONV_MAX = 1000;

    default clocking a_cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_frame_close;
        (state_q == adcsf_pkg::ADCSF_ST_FRAME) && cs_rise && pin_s;
    endsequence

    sequence s_conv_start;
        (state_q != adcsf_pkg::ADCSF_ST_CONV) ##1 (state_q == adcsf_pkg::ADCSF_ST_CONV);
    endsequence

    a_conv_ready_low: assert property ((state_q == adcsf_pkg::ADCSF_ST_CONV) |-> !ready_valid_indicator_o)
        else $error("ready high during conversion");

    a_conv_ends_acq: assert property (s_conv_start |-> ##[1:A_CONV_MAX]
        (state_q == adcsf_pkg::ADCSF_ST_ACQ) || (state_q == adcsf_pkg::ADCSF_ST_RESET))
        else $error("conversion did not end");

    a_conv_holds_cs: assert property (((state_q == adcsf_pkg::ADCSF_ST_CONV) && (tmr_q > TB'(1)) && pin_s)
        |=> (state_q == adcsf_pkg::ADCSF_ST_CONV))
        else $error("conversion left early");

    a_pin_low_reset: assert property (!pin_s |=> (state_q == adcsf_pkg::ADCSF_ST_RESET) && !ready_q)
        else $error("reset pin low not honoured");

    a_frame_open: assert property (((state_q == adcsf_pkg::ADCSF_ST_ACQ) && cs_fall && pin_s)
        |=> (state_q == adcsf_pkg::ADCSF_ST_FRAME) && !ready_q && (cmd_q == `ADCSF_NOP_WORD))
        else $error("frame start not handled");

    a_frame_close: assert property (s_frame_close |=> (state_q == adcsf_pkg::ADCSF_ST_CONV))
        else $error("select rise did not start conversion");

    a_short_nop: assert property ((s_frame_close and (cnt_q < `ADCSF_CNT_OPTIMAL)) |=> !cmd_valid_o)
        else $error("short frame produced a command");

    a_full_cmd: assert property ((s_frame_close and (edges_seen && (cnt_q >= `ADCSF_CNT_OPTIMAL)))
        |=> cmd_valid_o && (cmd_word_o == $past(shr_q)))
        else $error("full frame command lost");

    a_exit_ready: assert property (((state_q == adcsf_pkg::ADCSF_ST_EXIT) ##1
        (state_q == adcsf_pkg::ADCSF_ST_ACQ)) |-> ready_valid_indicator_o)
        else $error("ready not high after reset exit");

    a_reset_tristate: assert property (!reset_pin_n_i |-> !primary_serial_out_oe_o)
        else $error("serial out driven in reset");

endmodule : adcsf_top

// ---- adcsf_host_model.sv ----
`timescale 1ns/1ps

// Host controller: SPI mode 0 master, 48 ns serial clock, still between frames
module adcsf_host_model #(
    parameter int MIN_RESET_NS = 100          // Minimum low time of the reset pin
) (
    output logic      sclk_o,                 // Serial clock
    output logic      select_o,               // Select and convert start
    output logic      sdi_o,                  // Serial data to the device
    output logic      reset_pin_n_o,          // Device reset pin, active low
    input  wire logic sdo_i,                  // Serial data from the device
    input  wire logic oe_i                    // Device output enable
);
    localparam int HALF_NS = 24;              // Half of the serial clock period

    initial begin
        sclk_o = 1'b0;
        select_o = 1'b1;
        sdi_o = 1'b0;
        reset_pin_n_o = 1'b1;
    end

    // One frame on the primary lane only, low nbits of word sent MSB first
    task automatic frame(input int nbits, input logic [63:0] word, output logic [63:0] rx);
        rx = '0;
        select_o = 1'b0;
        #100;                                 // Let the frame open be seen first
        for (int i = nbits - 1; i >= 0; i--) begin // Full count, command in last bits
            sdi_o = word[i];
            #HALF_NS;
            sclk_o = 1'b1;
            rx = {rx[62:0], (oe_i === 1'b1) ? sdo_i : 1'bx}; // Undriven data is worth nothing
            #HALF_NS;
            sclk_o = 1'b0;
        end
        #(HALF_NS + 100);
        select_o = 1'b1;
        sdi_o = ~sdi_o;                       // No pull on the line: show the inverse once released
    endtask : frame

    // Plain select change, used for conversions without a frame
    task automatic set_select(input logic v);
        select_o = v;
    endtask : set_select

    // Reset pulse entry, select and clock low so that the exit is legal
    task automatic pin_low();
        sclk_o = 1'b0;
        select_o = 1'b0;
        #20;
        reset_pin_n_o = 1'b0;
        #MIN_RESET_NS;
    endtask : pin_low

    task automatic pin_high();
        reset_pin_n_o = 1'b1;
    endtask : pin_high

    // Link activity that a device held in reset must ignore
    task automatic sclk_burst();
        repeat (4) begin
            sdi_o = ~sdi_o;
            #HALF_NS;
            sclk_o = 1'b1;
            #HALF_NS;
            sclk_o = 1'b0;
        end
    endtask : sclk_burst
endmodule : adcsf_host_model

// ---- adc_serial_frame_and_state_control_test.sv ----
`timescale 1ns/1ps

module adc_serial_frame_and_state_control_test;
    localparam int CONV_CYC     = 20;         // Short counts keep the run brief
    localparam int POR_EXIT_CYC = 30;
    localparam int APP_EXIT_CYC = 10;
    localparam logic [31:0] WORD_A = 32'hA5C3_0F96; // First result word
    localparam logic [31:0] WORD_B = 32'h3C69_E187; // Second result word

    logic        mclk      = 1'b0;            // System clock
    logic        rst       = 1'b1;            // System reset
    logic        type_sel  = 1'b0;            // Reset type pin
    logic [31:0] conv_data = WORD_A;          // Converter core result
    logic        sclk;                        // Link clock from the host
    logic        sel;                         // Select line
    logic        sdi;                         // Data into the device
    logic        rst_pin_n;                   // Device reset pin
    logic        sdo;                         // Data out of the device
    logic        sdo_oe;                      // Its output enable
    logic        ready;                       // Ready indicator
    logic [31:0] cmd_word;                    // Command handed on
    logic        cmd_valid;                   // Command pulse
    logic        app_rst;                     // Application reset flag
    logic        por_rst;                     // Power-on reset flag
    logic        busy;                        // Conversion running
    logic [63:0] rx;                          // Bits taken by the host
    logic        got;                         // A command pulse was seen
    int          n;                           // Cycles waited
    int          fails     = 0;
    int          checked   = 0;

    // System clock, 10 ns period
    always #5 mclk = ~mclk;

    adcsf_top #(.CONV_CYC(CONV_CYC), .POR_EXIT_CYC(POR_EXIT_CYC), .APP_EXIT_CYC(APP_EXIT_CYC)) dut_u (
        .mclk_i(mclk), .rst_i(rst), .sclk_i(sclk), .reset_pin_n_i(rst_pin_n),
        .convert_start_select_i(sel), .serial_in_i(sdi), .reset_type_select_i(type_sel),
        .conv_data_i(conv_data), .primary_serial_out_o(sdo), .primary_serial_out_oe_o(sdo_oe),
        .ready_valid_indicator_o(ready), .cmd_word_o(cmd_word), .cmd_valid_o(cmd_valid),
        .app_reset_o(app_rst), .por_reset_o(por_rst), .conv_busy_o(busy));

    adcsf_host_model host_u (.sclk_o(sclk), .select_o(sel), .sdi_o(sdi), .reset_pin_n_o(rst_pin_n),
        .sdo_i(sdo), .oe_i(sdo_oe));

    task automatic print_verdict();
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            $display("wrong value at %0t: %s", $time, msg);
            fails++;
        end
    endtask : check

    function automatic logic pick(input int which);
        return (which == 0) ? ready : busy;
    endfunction : pick

    // Bounded wait for ready (0) or busy (1) high, counting clock cycles
    task automatic wait_for(input int which, input int limit, output int cnt);
        cnt = 0;
        while (pick(which) !== 1'b1) begin
            @(posedge mclk);
            #1;
            cnt++;
            if (cnt > limit) begin
                check(1'b0, 1'b1, "wait ran out");
                print_verdict();
            end
        end
    endtask : wait_for

    // Frame, then conversion; the host only starts again once ready is back
    task automatic do_frame(input int nbits, input logic [63:0] word);
        int busy_cnt;
        busy_cnt = 0;
        got = 1'b0;
        fork
            host_u.frame(nbits, word, rx);
            begin
                repeat (8) @(posedge mclk);
                #1;
                check(ready, 1'b0, "ready in frame");
            end
        join
        repeat (12) begin
            @(posedge mclk);
            #1;
            if (cmd_valid === 1'b1) got = 1'b1;
            if (busy === 1'b1) busy_cnt++;
        end
        check(sdo_oe, 1'b0, "output enable after frame");
        check(ready, 1'b0, "ready in conversion");
        wait_for(0, CONV_CYC + 8, n);
        check((busy_cnt + n >= CONV_CYC) && (busy_cnt + n <= CONV_CYC + 2), 1'b1, "conversion length");
        check(busy, 1'b0, "busy in acquire");
    endtask : do_frame

    task automatic t_power_on();
        #1;
        check(por_rst, 1'b1, "power-on flag");
        wait_for(0, POR_EXIT_CYC + 20, n);
        check((n >= POR_EXIT_CYC) && (n <= POR_EXIT_CYC + 8), 1'b1, "power-on exit delay");
        check(por_rst, 1'b0, "power-on flag in acquire");
    endtask : t_power_on

    // A frame with no clock edges is refused, its conversion still loads a result
    task automatic t_empty_frame();
        do_frame(0, 64'h0);
        check(got, 1'b0, "pulse on empty frame");
        check(cmd_word, 32'h0, "command on empty frame");
    endtask : t_empty_frame

    task automatic t_optimal();
        @(negedge mclk);
        conv_data = WORD_B;
        do_frame(32, 64'h0000_0000_1234_5678);
        check(rx[31:0], WORD_A, "optimal frame data");
        check(got, 1'b1, "optimal frame pulse");
        check(cmd_word, 32'h1234_5678, "optimal frame command");
    endtask : t_optimal

    task automatic t_short();
        do_frame(16, 64'h0000_0000_0000_FFFF);
        check(rx[15:0], WORD_B[31:16], "short frame data");
        check(got, 1'b0, "short frame pulse");
        check(cmd_word, 32'h0, "short frame command");
    endtask : t_short

    task automatic t_long();
        do_frame(40, 64'h0000_00C3_8765_4321);
        check(rx[39:8], WORD_B, "long frame data");
        check(rx[7:0], 8'hC3, "input reaches output");
        check(got, 1'b1, "long frame pulse");
        check(cmd_word, 32'h8765_4321, "long frame command");
    endtask : t_long

    task automatic t_ignore_select();
        int low_cnt;
        low_cnt = 0;
        host_u.frame(32, 64'h0000_0000_0F0F_F0F0, rx);
        wait_for(1, 12, n);
        #20;
        host_u.set_select(1'b0);
        #100;
        host_u.set_select(1'b1);
        wait_for(0, CONV_CYC + 8, n);
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (ready !== 1'b1) low_cnt++;
        end
        check(low_cnt, 0, "select during conversion");
        check(cmd_word, 32'h0F0F_F0F0, "command kept");
    endtask : t_ignore_select

    task automatic t_app_reset();
        @(negedge mclk);
        type_sel = 1'b1;
        host_u.pin_low();
        repeat (10) @(posedge mclk);
        #1;
        check(app_rst, 1'b1, "application flag");
        check(ready, 1'b0, "ready in reset");
        check(sdo_oe, 1'b0, "output in reset");
        check(cmd_word, 32'h0, "command in reset");
        host_u.sclk_burst();
        host_u.pin_high();
        wait_for(0, APP_EXIT_CYC + 20, n);
        check((n >= APP_EXIT_CYC) && (n <= APP_EXIT_CYC + 8), 1'b1, "application exit delay");
        check(app_rst, 1'b0, "application flag cleared");
        host_u.set_select(1'b1);
        repeat (10) @(posedge mclk);
        wait_for(0, CONV_CYC + 8, n);
        do_frame(32, 64'h0000_0000_ABCD_0123);
        check(rx[31:0], WORD_B, "data after reset");
        check(cmd_word, 32'hABCD_0123, "count after reset");
    endtask : t_app_reset

    task automatic t_por_pin();
        @(negedge mclk);
        type_sel = 1'b0;
        host_u.pin_low();
        repeat (10) @(posedge mclk);
        #1;
        check(por_rst, 1'b1, "power-on flag from pin");
        check(app_rst, 1'b0, "no application flag");
        host_u.pin_high();
        wait_for(0, POR_EXIT_CYC + 20, n);
        check((n >= POR_EXIT_CYC) && (n <= POR_EXIT_CYC + 8), 1'b1, "pin exit delay");
    endtask : t_por_pin

    // Main sequence; reset, reset type and result inputs change on the falling clock edge
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        t_power_on();
        t_empty_frame();
        t_optimal();
        t_short();
        t_long();
        t_ignore_select();
        t_app_reset();
        t_por_pin();
        print_verdict();
    end
endmodule : adc_serial_frame_and_state_control_test
